// [rtc_consts.vh]
// Constants for the rate temperature compensation block.
// Assumes includers use these names only; no logic lives here.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
// ----------------------------------------
// Word indices, byte address is four times
// ----------------------------------------
`define RTC_IDX_TEMP   8'h04
`define RTC_IDX_BASE   8'h3c
`define RTC_IDX_RCFG   8'h3d
`define RTC_IDX_SF4    8'h48
`define RTC_IDX_PROG   8'h50
`define RTC_IDX_NVRA   8'h51
`define RTC_IDX_NVRD   8'h52
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RTC_RSEL_BIT   31
`define RTC_SLOT_HI    12
`define RTC_SLOT_LO    8
`define RTC_TSEL_BIT   3
`define RTC_GAIN_HI    17
`define RTC_GAIN_LO    4
`define RTC_OFS_HI     31
`define RTC_OFS_LO     18
`define RTC_DEF_TEMP   32'h00008000
`define RTC_DEF_RCFG   32'h80000100
`define RTC_DEF_SF0    32'h08000000
`define RTC_SLOT_FULL  5'h1f
// ----------------------------------------
// Fixed point scalings
// ----------------------------------------
`define RTC_SF_SETTING 10000
`define RTC_TEMP_LSB_C 20
`define RTC_T_MUL_SH   6
`define RTC_GAIN_FRAC  11
`define RTC_SF_FRAC    27
`define RTC_B1_SH      20
`define RTC_B2_SH      32
`define RTC_B3_SH      53
`define RTC_B4_SH      73
`define RTC_S1_SH      19
`define RTC_S2_SH      28
`define RTC_S3_SH      45
`define RTC_S4_SH      65
`endif

// [rtc_host.sv]
// Host model: APB master on the register side.
// Assumes callers enter xfer just after a rising pclk edge.
`timescale 1ns/1ps
module rtc_host (
	input  wire        pclk,
	input  wire        pready,
	output reg         psel = 1'b0,
	output reg         penable = 1'b0,
	output reg         pwrite = 1'b0,
	output reg  [9:0]  paddr = 10'h0,
	output reg  [31:0] pwdata = 32'h0
);
	task xfer(input w, input [7:0] i, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= {i, 2'b00};
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			psel <= 1'b0;
			penable <= 1'b0;
			// Idle edge so the next call never reassigns in this step
			@(posedge pclk);
		end
	endtask
endmodule

// [rtc_props.sv]
// Port checker for the rate compensation block.
// Assumes one clock pclk and presetn asynchronous, active low.
`timescale 1ns/1ps
module rtc_props (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        rate_raw_valid,
	input wire [23:0] rate_out,
	input wire        rate_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse)
		else $error("pready held");
	property p_rdy_cause; pready |-> $past(psel && penable); endproperty
	a_rdy_cause: assert property (p_rdy_cause)
		else $error("pready without access");
	property p_acc; psel && penable && !pready |=> pready; endproperty
	a_acc: assert property (p_acc)
		else $error("access not answered");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err)
		else $error("pslverr alone");
	property p_err0; pready && pslverr && !pwrite |-> prdata == 32'h0;
	endproperty
	a_err0: assert property (p_err0)
		else $error("refused read not zero");
	property p_lat; rate_ready |-> $past(rate_raw_valid, 8); endproperty
	a_lat: assert property (p_lat)
		else $error("rate latency");
	property p_rr; rate_ready |=> !rate_ready; endproperty
	a_rr: assert property (p_rr)
		else $error("rate_ready held");
	property p_hold; !$stable(rate_out) |-> rate_ready; endproperty
	a_hold: assert property (p_hold)
		else $error("rate_out moved");
	c_rate: cover property (rate_ready);
	c_err: cover property (pready && pslverr);
	c_wr: cover property (pready && pwrite);
endmodule
bind rtc_rate_temp_comp rtc_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rate_raw_valid(rate_raw_valid),
	.rate_out(rate_out), .rate_ready(rate_ready));

// [rtc_rate_temp_comp.v]
// Rate temperature compensation with APB system registers and store.
// Assumes raw samples come from logic on pclk; nvm_por_n is power-on only.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_rate_temp_comp (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        nvm_por_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [9:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [23:0] rate_raw,
	input  wire        rate_raw_valid,
	input  wire [13:0] temp_raw,
	input  wire        temp_raw_valid,
	output reg  [23:0] rate_out,
	output reg         rate_ready,
	output reg  [17:0] temp_out
);
	localparam NREG   = 13;
	localparam K_B0   = 2;
	localparam K_SF0  = 3;
	localparam K_TEMP_MIDPOINT = 4;
	localparam K_B1   = 5;
	localparam K_SF1  = 6;
	localparam K_B2   = 7;
	localparam K_SF2  = 8;
	localparam K_B3   = 9;
	localparam K_SF3  = 10;
	localparam K_B4   = 11;
	localparam K_SF4  = 12;
	localparam S_IDLE = 8'h01;
	localparam S_X    = 8'h02;
	localparam S_P2   = 8'h04;
	localparam S_P3   = 8'h08;
	localparam S_P4   = 8'h10;
	localparam S_TERM = 8'h20;
	localparam S_DIV  = 8'h40;
	localparam S_OUT  = 8'h80;
	localparam signed [127:0] QMAX = 128'sh7fffff;
	localparam signed [127:0] QMIN = -128'sh800000;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [4:0] k_of;
		input [7:0] idx;
		reg   [7:0] d;
		begin
			d = idx - `RTC_IDX_BASE;
			if (idx == `RTC_IDX_TEMP)
				k_of = 5'h10;
			else if (idx >= `RTC_IDX_RCFG && idx <= `RTC_IDX_SF4)
				k_of = {1'b1, d[3:0]};
			else
				k_of = 5'h00;
		end
	endfunction

	function [31:0] def_of;
		input integer k;
		begin
			case (k)
			0:       def_of = `RTC_DEF_TEMP;
			1:       def_of = `RTC_DEF_RCFG;
			K_SF0:   def_of = `RTC_DEF_SF0;
			default: def_of = 32'h00000000;
			endcase
		end
	endfunction

	reg  [31:0] sys_ff [0:NREG-1];
	reg  [31:0] cmt_ff [0:NREG-1];
	reg  [31:0] pnd_ff [0:NREG-1];
	reg         load_ff;
	reg         temp_once_ff;
	reg  [7:0]  nvra_ff;
	reg  [7:0]  st_ff;
	reg  signed [23:0]  raw_ff;
	reg  [13:0] temp_lat_ff;
	reg  signed [20:0]  x_ff;
	reg  signed [41:0]  x2_ff;
	reg  signed [62:0]  x3_ff;
	reg  signed [83:0]  x4_ff;
	reg  signed [63:0]  bias_ff;
	reg  signed [63:0]  scl_ff;
	reg  [23:0] quo_ff;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire [7:0] idx     = paddr[9:2];
	wire [4:0] wk      = k_of(idx);
	wire       setup   = psel & penable & ~pready;
	wire       acc     = psel & penable & pready;
	wire       is_ctl  = (idx == `RTC_IDX_PROG) | (idx == `RTC_IDX_NVRA) |
	                     (idx == `RTC_IDX_NVRD);
	wire       mapped  = wk[4] | is_ctl;
	wire       wr_sys  = acc & pwrite & wk[4] & ~load_ff;
	wire       prog_go = acc & pwrite & (idx == `RTC_IDX_PROG);
	wire [4:0] pk      = k_of(pwdata[7:0]);
	wire [4:0] cslot   = cmt_ff[1][`RTC_SLOT_HI:`RTC_SLOT_LO];
	wire [4:0] sslot   = sys_ff[1][`RTC_SLOT_HI:`RTC_SLOT_LO];
	wire       full    = (cslot == `RTC_SLOT_FULL);
	// Commit only on a single thermometer step of the stored counter
	wire       commit  = prog_go & pk[4] & (pk[3:0] == 4'h1) & ~full &
	                     (sslot == {cslot[3:0], 1'b1});
	wire [4:0] rk      = k_of(nvra_ff);
	wire [31:0] nv_rd  = ~rk[4] ? 32'h00000000 :
	                     (rk[3:0] >= 4'h2) ? pnd_ff[rk[3:0]] :
	                     cmt_ff[rk[3:0]];

	reg [31:0] rd_w;
	always @* begin
		rd_w = 32'h00000000;
		if (wk[4])
			rd_w = sys_ff[wk[3:0]];
		else if (idx == `RTC_IDX_NVRA)
			rd_w = {24'h000000, nvra_ff};
		else if (idx == `RTC_IDX_NVRD)
			rd_w = nv_rd;
	end

	// One wait state: pready rises in the second access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			nvra_ff <= 8'h00;
			load_ff <= 1'b1;
		end else begin
			load_ff <= 1'b0;
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup)
				prdata <= pwrite ? 32'h00000000 : rd_w;
			if (acc & pwrite & (idx == `RTC_IDX_NVRA))
				nvra_ff <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// System registers and store, per word
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NREG; i = i + 1) begin : g_word
			// Reload from the committed image right after reset
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					sys_ff[i] <= def_of(i);
				else if (load_ff)
					sys_ff[i] <= cmt_ff[i];
				else if (wr_sys && wk[3:0] == i)
					sys_ff[i] <= pwdata;
			end
			// Store survives presetn; pending words overwrite, never revert
			always @(posedge pclk or negedge nvm_por_n) begin
				if (!nvm_por_n) begin
					cmt_ff[i] <= def_of(i);
					pnd_ff[i] <= def_of(i);
				end else if (i == 0) begin
					if (prog_go && pk == 5'h10 && !temp_once_ff) begin
						cmt_ff[i] <= sys_ff[i];
						pnd_ff[i] <= sys_ff[i];
					end
				end else if (commit) begin
					cmt_ff[i] <= (i == 1) ? sys_ff[i] : pnd_ff[i];
					pnd_ff[i] <= (i == 1) ? sys_ff[i] : pnd_ff[i];
				end else if (i >= 2 && prog_go && pk[4] &&
				             pk[3:0] == i && !full) begin
					pnd_ff[i] <= sys_ff[i];
				end
			end
		end
	endgenerate

	// The temperature word at index 04 may be programmed once only
	always @(posedge pclk or negedge nvm_por_n) begin
		if (!nvm_por_n)
			temp_once_ff <= 1'b0;
		else if (prog_go && pk == 5'h10)
			temp_once_ff <= 1'b1;
	end

	// ----------------------------------------
	// Polynomial terms
	// ----------------------------------------
	wire [20:0] nxt_x = {1'b0, temp_lat_ff, 6'h00} -
	                    {1'b0, sys_ff[K_TEMP_MIDPOINT][19:0]};
	wire signed [127:0] tb1 = $signed(sys_ff[K_B1][29:0]) * x_ff;
	wire signed [127:0] tb2 = $signed(sys_ff[K_B2][19:0]) * x2_ff;
	wire signed [127:0] tb3 = $signed(sys_ff[K_B3][19:0]) * x3_ff;
	wire signed [127:0] tb4 = $signed(sys_ff[K_B4][18:0]) * x4_ff;
	wire signed [127:0] ts1 = $signed(sys_ff[K_SF1][29:0]) * x_ff;
	wire signed [127:0] ts2 = $signed(sys_ff[K_SF2][20:0]) * x2_ff;
	wire signed [127:0] ts3 = $signed(sys_ff[K_SF3][19:0]) * x3_ff;
	wire signed [127:0] ts4 = $signed(sys_ff[K_SF4][18:0]) * x4_ff;
	wire signed [127:0] bias_w = $signed(sys_ff[K_B0][23:0]) +
	                             (tb1 >>> `RTC_B1_SH) + (tb2 >>> `RTC_B2_SH) +
	                             (tb3 >>> `RTC_B3_SH) +
	                             (tb4 >>> `RTC_B4_SH);
	// Scale words already carry the 1/10000 factor, so it cancels here
	wire signed [127:0] scl_w = $signed(sys_ff[K_SF0][30:0]) +
	                            (ts1 >>> `RTC_S1_SH) + (ts2 >>> `RTC_S2_SH) +
	                            (ts3 >>> `RTC_S3_SH) +
	                            (ts4 >>> `RTC_S4_SH);
	wire signed [127:0] num_w = ($signed(raw_ff) - bias_ff) <<<
	                            `RTC_SF_FRAC;
	// Zero scale would divide by zero; output zero instead
	wire signed [127:0] quo_w = (scl_ff == 64'h0) ? 128'sh0 :
	                            num_w / scl_ff;
	wire [23:0] sat_w = (quo_w > QMAX) ? 24'h7fffff :
	                    (quo_w < QMIN) ? 24'h800000 : quo_w[23:0];

	// ----------------------------------------
	// Temperature output
	// ----------------------------------------
	wire [27:0] tprod = sys_ff[0][`RTC_GAIN_HI:`RTC_GAIN_LO] * temp_lat_ff;
	wire [17:0] tcal  = {1'b0, tprod[27:`RTC_GAIN_FRAC]} -
	                    {4'h0, sys_ff[0][`RTC_OFS_HI:`RTC_OFS_LO]};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_lat_ff <= 14'h0000;
			temp_out    <= 18'h00000;
		end else begin
			if (temp_raw_valid)
				temp_lat_ff <= temp_raw;
			// Result counts 20 LSB per degree when calibrated
			temp_out <= sys_ff[0][`RTC_TSEL_BIT] ? tcal :
			            {4'h0, temp_lat_ff};
		end
	end

	// ----------------------------------------
	// Rate pipeline
	// ----------------------------------------
	// Sequential stages trade latency; S_P2 to S_P4 use one multiplier each, S_TERM forms all eight terms at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff      <= S_IDLE;
			raw_ff     <= 24'h000000;
			x_ff       <= 21'h000000;
			x2_ff      <= 42'h0;
			x3_ff      <= 63'h0;
			x4_ff      <= 84'h0;
			bias_ff    <= 64'h0;
			scl_ff     <= 64'h0;
			quo_ff     <= 24'h000000;
			rate_out   <= 24'h000000;
			rate_ready <= 1'b0;
		end else begin
			rate_ready <= 1'b0;
			case (st_ff)
			S_IDLE: begin
				if (rate_raw_valid && !load_ff) begin
					raw_ff <= rate_raw;
					st_ff  <= S_X;
				end
			end
			S_X: begin
				x_ff  <= nxt_x;
				st_ff <= S_P2;
			end
			S_P2: begin
				x2_ff <= x_ff * x_ff;
				st_ff <= S_P3;
			end
			S_P3: begin
				x3_ff <= x2_ff * x_ff;
				st_ff <= S_P4;
			end
			S_P4: begin
				x4_ff <= x3_ff * x_ff;
				st_ff <= S_TERM;
			end
			S_TERM: begin
				bias_ff <= bias_w[63:0];
				scl_ff  <= scl_w[63:0];
				st_ff   <= S_DIV;
			end
			S_DIV: begin
				quo_ff <= sat_w;
				st_ff  <= S_OUT;
			end
			S_OUT: begin
				rate_out   <= sys_ff[1][`RTC_RSEL_BIT] ? quo_ff :
				              raw_ff;
				rate_ready <= 1'b1;
				st_ff      <= S_IDLE;
			end
			default: st_ff <= S_IDLE;
			endcase
		end
	end
endmodule

// [rtc_rate_temp_comp_tb.sv]
// Testbench for the rate compensation block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_rate_temp_comp_tb;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         nvm_por_n = 1'b0;
	reg  [23:0] rate_raw = 24'h0;
	reg         rate_raw_valid = 1'b0;
	reg  [13:0] temp_raw = 14'h0;
	reg         temp_raw_valid = 1'b0;
	wire        psel, penable, pwrite, pready, pslverr, rate_ready;
	wire [9:0]  paddr;
	wire [31:0] pwdata, prdata;
	wire [23:0] rate_out;
	wire [17:0] temp_out;
	integer     miscompares = 0;
	integer     comparisons = 0;
	integer     cycles = 0;
	integer     k, r;
	reg  [33:0] q_apb[$];
	reg  [23:0] q_rate[$];
	reg  [33:0] e;
	reg  [4:0]  slot;
	always #20 pclk = ~pclk;
	rtc_host host (.pclk(pclk), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	rtc_rate_temp_comp dut (.pclk(pclk), .presetn(presetn),
		.nvm_por_n(nvm_por_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rate_raw(rate_raw),
		.rate_raw_valid(rate_raw_valid), .temp_raw(temp_raw),
		.temp_raw_valid(temp_raw_valid), .rate_out(rate_out),
		.rate_ready(rate_ready), .temp_out(temp_out));
	task check(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("Compares %0d, mismatches %0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task wr(input [7:0] i, input [31:0] d);
		begin
			q_apb.push_back({2'b00, 32'h0});
			host.xfer(1'b1, i, d);
		end
	endtask
	task rd(input [7:0] i, input er, input [31:0] d);
		begin
			q_apb.push_back({1'b1, er, d});
			host.xfer(1'b0, i, 32'h0);
		end
	endtask
	task rate(input [23:0] raw, input [23:0] ex);
		begin
			rate_raw <= raw;
			rate_raw_valid <= 1'b1;
			q_rate.push_back(ex);
			@(posedge pclk);
			rate_raw_valid <= 1'b0;
			// Keeps the twelve cycle spacing between samples
			repeat (11) @(posedge pclk);
		end
	endtask
	task temp(input [13:0] t);
		begin
			temp_raw <= t;
			temp_raw_valid <= 1'b1;
			@(posedge pclk);
			temp_raw_valid <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
	task rst;
		begin
			presetn <= 1'b0;
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
			// Load cycle swallows early writes
			repeat (3) @(posedge pclk);
		end
	endtask
	// ----------------------------------------
	// Result watcher and timeout
	// ----------------------------------------
	always @(posedge pclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			finish_test;
		end else begin
			if (pready === 1'b1) begin
				e = q_apb.pop_front();
				check(pslverr, e[32]);
				if (e[33])
					check(prdata, e[31:0]);
			end
			if (rate_ready === 1'b1)
				check(rate_out, q_rate.pop_front());
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		r = $urandom(15);
		repeat (8) @(posedge pclk);
		nvm_por_n <= 1'b1;
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(`RTC_IDX_RCFG, 1'b0, `RTC_DEF_RCFG);
		rd(`RTC_IDX_TEMP, 1'b0, `RTC_DEF_TEMP);
		rd(8'h3f, 1'b0, `RTC_DEF_SF0);
		rd(8'h60, 1'b1, 32'h0);
		temp(14'h1);
		check(temp_out, 32'h1);
		r = 100 + $urandom % 100000;
		rate(2 * r + 5, 2 * r + 5);
		wr(8'h3e, 32'h5);
		rate(2 * r + 5, 2 * r);
		wr(8'h3f, 32'h10000000);
		rate(2 * r + 5, r);
		wr(8'h41, 32'h00100000);
		rate(2 * r + 5, r - 32);
		wr(8'h40, 32'd64);
		rate(2 * r + 5, r);
		// Higher orders: x is 2^16, scale sums to 2^27, bias to -6
		temp(14'd1024);
		check(temp_out, 32'd1024);
		wr(8'h40, 32'h0);
		wr(8'h41, 32'h0);
		wr(8'h43, 32'h000ffff0);
		wr(8'h45, 32'd96);
		wr(8'h47, 32'd1024);
		wr(8'h42, 32'h10000000);
		wr(8'h44, 32'h00080000);
		wr(8'h46, 32'h00040000);
		wr(8'h48, 32'h00020000);
		wr(8'h3f, 32'h055f0000);
		rate(2 * r + 5, 2 * r + 11);
		wr(8'h3d, 32'h00000100);
		rate(2 * r + 5, 2 * r + 5);
		wr(8'h04, {14'd3, 14'h0800, 1'b1, 3'b000});
		temp(14'd100);
		check(temp_out, 32'd97);
		wr(8'h04, {14'd3, 14'h1000, 1'b1, 3'b000});
		temp(14'd100);
		check(temp_out, 32'd197);
		wr(8'h50, 32'h04);
		wr(8'h50, 32'h3f);
		wr(8'h51, 32'h3f);
		rd(8'h52, 1'b0, 32'h055f0000);
		wr(8'h3d, 32'h80000700);
		wr(8'h50, 32'h3d);
		// Temperature word takes one programming only
		wr(8'h04, 32'h0);
		wr(8'h50, 32'h04);
		rst;
		rd(8'h3f, 1'b0, `RTC_DEF_SF0);
		rd(8'h04, 1'b0, {14'd3, 14'h1000, 1'b1, 3'b000});
		slot = 5'h01;
		for (k = 0; k < 5; k = k + 1) begin
			slot = {slot[3:0], 1'b1};
			wr(8'h3f, 32'h08000001 + k);
			wr(8'h50, 32'h3f);
			wr(8'h3d, {1'b1, 18'h0, slot, 8'h0});
			wr(8'h50, 32'h3d);
			rst;
			rd(8'h3f, 1'b0, 32'h08000001 + (k < 4 ? k : 3));
			rd(8'h3d, 1'b0, {1'b1, 18'h0, slot, 8'h0});
		end
		finish_test;
	end
endmodule
